//--- src/self_program_boot_partition.sv
// Self-programming flash sequencer seen by the CPU core: control/status register, timed store window,
// page buffer fill, page erase/write timing and readable-region gating.
// Assumes the core drives the register port, the store strobe and the Z pointer on mclk.
//
// Notes on behaviour
// - Boot size fuses 11/10/01/00 give boot start 0x1F80/0x1F00/0x1E00/0x1C00.
// - Readable region is 112 pages below 0x1C00, non-readable region 16 pages above.
// - Flash words are addressed by a 13-bit program counter.
// - Buffer word index comes from pointer bits 6 to 1.
// - Counter top bit sits at pointer bit 13.
// - Word field top bit sits at pointer bit 6.
// - Page for erase and write comes from pointer bits 13 to 7.
// - Pointer bit 0 is ignored by stores and selects the byte for loads.
// - During erase or write only non-readable region code may be fetched.
// - Busy flag stays set until a re-enable command clears it.
// - Enable bit stays set until the running operation finishes.
// - A command is taken only if the store comes within four cycles.
// - An EEPROM write in progress blocks all flash programming.
// - Erase, write and lock operations last between 3.7 ms and 4.5 ms.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "selfprog_map.svh"

module self_program_boot_partition
    import selfprog_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = (`PROG_TIME_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    input  wire logic [`ADDR_W-1:0]   reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    input  wire logic                 spm_exec,
    input  wire logic [15:0]          z_ptr,
    input  wire logic [7:0]           r0_data,
    input  wire logic [7:0]           r1_data,
    input  wire logic                 eeprom_write_in_progress_bit,
    input  wire logic                 boot_size_fuse_hi,
    input  wire logic                 boot_size_fuse_lo,
    input  wire logic [`PC_W-1:0]     fetch_addr,
    output logic                      fetch_denied,
    output logic                      lpm_byte_sel,
    output logic [`PC_W-1:0]          boot_start,
    output logic                      page_erase_pulse,
    output logic                      page_write_pulse,
    output logic                      lock_write_pulse,
    output logic [6:0]                page_select_field,
    output logic                      buf_wr_pulse,
    output logic [5:0]                word_in_page_field,
    output logic [15:0]               buf_wr_data,
    output logic                      readable_region_busy_flag,
    output logic                      selfprog_enable_bit
);

    // --------------------------------------------------------------------
    // Decoding helpers
    // --------------------------------------------------------------------
    function automatic logic [`PC_W-1:0] boot_start_of(input logic [1:0] sz);
        unique case (sz)
            2'b11:   boot_start_of = `BOOT_START_128;
            2'b10:   boot_start_of = `BOOT_START_256;
            2'b01:   boot_start_of = `BOOT_START_512;
            2'b00:   boot_start_of = `BOOT_START_1024;
        endcase
    endfunction

    // The limit is fixed by the part, not by the boot fuses, so a small boot section still leaves
    // the whole upper 16 pages fetchable during programming.
    function automatic logic in_readable_region(input logic [`PC_W-1:0] a);
        in_readable_region = (a < `RWW_LIMIT);
    endfunction

    localparam logic [`TIMER_W-1:0] PROG_LOAD = `TIMER_W'(PROG_CYCLES - 1);

    seq_regs_t s_reg;
    seq_regs_t s_next;

    logic csr_wr;
    logic csr_rd;
    logic [7:0] csr_view;
    logic [`PC_W-1:0] z_word_addr;

    // --------------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------------
    always_comb begin
        s_next             = s_reg;
        s_next.erase_pulse = 1'b0;
        s_next.write_pulse = 1'b0;
        s_next.lock_pulse  = 1'b0;
        s_next.buf_wr      = 1'b0;
        s_next.rdata       = 8'h00;

        csr_wr      = reg_wr && (reg_addr == `CSR_ADDR);
        csr_rd      = reg_rd && (reg_addr == `CSR_ADDR);
        z_word_addr = z_ptr[`Z_PC_TOP:`Z_WORD_LO];

        csr_view                  = 8'h00;
        csr_view[`CSR_ENABLE_POS] = s_reg.enable;
        csr_view[`CSR_ERASE_POS]  = s_reg.cmd_erase;
        csr_view[`CSR_WRITE_POS]  = s_reg.cmd_write;
        csr_view[`CSR_LOCK_POS]   = s_reg.cmd_lock;
        csr_view[`CSR_REEN_POS]   = s_reg.cmd_reen;
        csr_view[`CSR_BUSY_POS]   = s_reg.busy;
        if (csr_rd) begin
            s_next.rdata = csr_view;
        end

        // Fuse pins are static straps but come from outside the clock, so they pass two flops.
        s_next.fuse_s1    = {boot_size_fuse_hi, boot_size_fuse_lo};
        s_next.fuse_s2    = s_reg.fuse_s1;
        s_next.boot_start = boot_start_of(s_reg.fuse_s2);

        s_next.byte_sel     = z_ptr[`Z_BYTE_SEL];
        // A lock-bit write leaves the whole flash readable, so only an erase or a page write gates fetches.
        s_next.fetch_denied = (s_reg.st == ST_PROG) && (s_reg.cmd_erase || s_reg.cmd_write) &&
                              in_readable_region(fetch_addr);

        unique case (s_reg.st)
            ST_IDLE: begin
                // A write while an earlier operation runs never reaches here; one during an EEPROM
                // write is dropped so the flash can never start a program cycle under it.
                if (csr_wr && reg_wdata[`CSR_ENABLE_POS] && !eeprom_write_in_progress_bit) begin
                    s_next.st        = ST_ARMED;
                    s_next.win_cnt   = 3'h0;
                    s_next.enable    = 1'b1;
                    s_next.cmd_erase = reg_wdata[`CSR_ERASE_POS];
                    s_next.cmd_write = reg_wdata[`CSR_WRITE_POS];
                    s_next.cmd_lock  = reg_wdata[`CSR_LOCK_POS];
                    s_next.cmd_reen  = reg_wdata[`CSR_REEN_POS];
                end
            end
            ST_ARMED: begin
                if (spm_exec) begin
                    s_next.page_addr = z_word_addr[`PC_W-1:`Z_PAGE_LO-`Z_WORD_LO];
                    if (s_reg.cmd_erase || s_reg.cmd_write || s_reg.cmd_lock) begin
                        s_next.st          = ST_PROG;
                        s_next.timer       = PROG_LOAD;
                        s_next.erase_pulse = s_reg.cmd_erase;
                        s_next.write_pulse = s_reg.cmd_write && !s_reg.cmd_erase;
                        s_next.lock_pulse  = s_reg.cmd_lock && !s_reg.cmd_erase && !s_reg.cmd_write;
                        // Lock-bit writes leave the whole flash readable.
                        s_next.busy        = s_reg.busy || s_reg.cmd_erase || s_reg.cmd_write;
                    end else begin
                        s_next.st     = ST_IDLE;
                        s_next.enable = 1'b0;
                        if (s_reg.cmd_reen) begin
                            s_next.busy = 1'b0;
                        end else begin
                            s_next.buf_wr   = 1'b1;
                            s_next.buf_idx  = z_word_addr[`Z_WORD_TOP-`Z_WORD_LO:0];
                            s_next.buf_data = {r1_data, r0_data};
                        end
                        s_next.cmd_reen = 1'b0;
                    end
                end else if (s_reg.win_cnt == `SPM_WINDOW - 3'h1) begin
                    s_next.st        = ST_IDLE;
                    s_next.enable    = 1'b0;
                    s_next.cmd_erase = 1'b0;
                    s_next.cmd_write = 1'b0;
                    s_next.cmd_lock  = 1'b0;
                    s_next.cmd_reen  = 1'b0;
                end else begin
                    s_next.win_cnt = s_reg.win_cnt + 3'h1;
                end
            end
            ST_PROG: begin
                if (s_reg.timer == '0) begin
                    s_next.st        = ST_IDLE;
                    s_next.enable    = 1'b0;
                    s_next.cmd_erase = 1'b0;
                    s_next.cmd_write = 1'b0;
                    s_next.cmd_lock  = 1'b0;
                end else begin
                    s_next.timer = s_reg.timer - `TIMER_W'(1);
                end
            end
            default: begin
                s_next.st     = ST_IDLE;
                s_next.enable = 1'b0;
            end
        endcase
    end

    // --------------------------------------------------------------------
    // State register
    // --------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_reg            <= '0;
            s_reg.st         <= ST_IDLE;
            s_reg.boot_start <= `BOOT_START_1024;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata                 = s_reg.rdata;
    assign fetch_denied              = s_reg.fetch_denied;
    assign lpm_byte_sel              = s_reg.byte_sel;
    assign boot_start                = s_reg.boot_start;
    assign page_erase_pulse          = s_reg.erase_pulse;
    assign page_write_pulse          = s_reg.write_pulse;
    assign lock_write_pulse          = s_reg.lock_pulse;
    assign page_select_field         = s_reg.page_addr;
    assign buf_wr_pulse              = s_reg.buf_wr;
    assign word_in_page_field        = s_reg.buf_idx;
    assign buf_wr_data               = s_reg.buf_data;
    assign readable_region_busy_flag = s_reg.busy;
    assign selfprog_enable_bit       = s_reg.enable;

    // --------------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------------
    property p_window_expire;
        @(posedge mclk) disable iff (!resetn)
        (s_reg.st == ST_IDLE && s_next.st == ST_ARMED) ##1 (!spm_exec) [*4] |=> !selfprog_enable_bit;
    endproperty
    a_window_expire: assert property (p_window_expire) else $error("Enable bit survived the store window.");

    property p_eeprom_block;
        @(posedge mclk) disable iff (!resetn)
        (s_reg.st == ST_IDLE && eeprom_write_in_progress_bit) |=> !selfprog_enable_bit;
    endproperty
    a_eeprom_block: assert property (p_eeprom_block) else $error("Command armed during EEPROM write.");

    property p_prog_length;
        @(posedge mclk) disable iff (!resetn)
        $rose(page_erase_pulse) |-> selfprog_enable_bit [*8];
    endproperty
    a_prog_length: assert property (p_prog_length) else $error("Erase ended too early.");

    property p_prog_done;
        @(posedge mclk) disable iff (!resetn)
        (s_reg.st == ST_PROG && s_reg.timer == '0) |=> !selfprog_enable_bit;
    endproperty
    a_prog_done: assert property (p_prog_done) else $error("Enable bit not cleared after programming.");

    property p_fill_clears;
        @(posedge mclk) disable iff (!resetn)
        buf_wr_pulse |-> !selfprog_enable_bit && word_in_page_field == $past(z_ptr[`Z_WORD_TOP:`Z_WORD_LO]);
    endproperty
    a_fill_clears: assert property (p_fill_clears) else $error("Buffer fill mismatch.");

    property p_busy_on_write;
        @(posedge mclk) disable iff (!resetn)
        (page_erase_pulse || page_write_pulse) |-> readable_region_busy_flag;
    endproperty
    a_busy_on_write: assert property (p_busy_on_write) else $error("Busy flag not set by erase or write.");

    property p_busy_holds;
        @(posedge mclk) disable iff (!resetn)
        (readable_region_busy_flag && !(s_reg.st == ST_ARMED && spm_exec && s_reg.cmd_reen)) |=>
            readable_region_busy_flag;
    endproperty
    a_busy_holds: assert property (p_busy_holds) else $error("Busy flag dropped without re-enable.");

    property p_fetch_gate;
        @(posedge mclk) disable iff (!resetn)
        (s_reg.st == ST_PROG && fetch_addr >= `RWW_LIMIT) |=> !fetch_denied;
    endproperty
    a_fetch_gate: assert property (p_fetch_gate) else $error("Upper region fetch denied.");

    property p_page_addr;
        @(posedge mclk) disable iff (!resetn)
        page_write_pulse |-> page_select_field == $past(z_ptr[`Z_PC_TOP:`Z_PAGE_LO]);
    endproperty
    a_page_addr: assert property (p_page_addr) else $error("Page select taken from wrong bits.");

    property p_boot_start;
        @(posedge mclk) disable iff (!resetn)
        (s_reg.fuse_s2 == 2'b11) |=> boot_start == `BOOT_START_128;
    endproperty
    a_boot_start: assert property (p_boot_start) else $error("Boot start decode wrong.");

    property p_fetch_deny;
        @(posedge mclk) disable iff (!resetn)
        (s_reg.st == ST_PROG && (s_reg.cmd_erase || s_reg.cmd_write) && fetch_addr < `RWW_LIMIT) |=> fetch_denied;
    endproperty
    a_fetch_deny: assert property (p_fetch_deny) else $error("Readable region fetch allowed during programming.");

    property p_read_view;
        @(posedge mclk) disable iff (!resetn)
        csr_rd |=> (reg_rdata[`CSR_ENABLE_POS] == $past(s_reg.enable)) &&
                   (reg_rdata[`CSR_BUSY_POS] == $past(s_reg.busy));
    endproperty
    a_read_view: assert property (p_read_view) else $error("Status read does not show enable and busy.");

    property p_fill_accept;
        @(posedge mclk) disable iff (!resetn)
        (s_reg.st == ST_ARMED && spm_exec && !s_reg.cmd_erase && !s_reg.cmd_write && !s_reg.cmd_lock &&
         !s_reg.cmd_reen) |=> buf_wr_pulse;
    endproperty
    a_fill_accept: assert property (p_fill_accept) else $error("Store inside the window did not fill.");

    property p_byte_sel;
        @(posedge mclk) disable iff (!resetn)
        1'b1 |=> lpm_byte_sel == $past(z_ptr[`Z_BYTE_SEL]);
    endproperty
    a_byte_sel: assert property (p_byte_sel) else $error("Byte select not taken from pointer bit 0.");

endmodule // self_program_boot_partition

//--- src/selfprog_map.svh
// Constants of the self-programming sequencer: register map, Z pointer fields, boot sizes and timing.
// Assumes inclusion by bare name from the package and the design module.
`ifndef SELFPROG_MAP_SVH
`define SELFPROG_MAP_SVH

`define CSR_ADDR            6'h37
`define ADDR_W              6
`define CSR_ENABLE_POS      0
`define CSR_ERASE_POS       1
`define CSR_WRITE_POS       2
`define CSR_LOCK_POS        3
`define CSR_REEN_POS        4
`define CSR_BUSY_POS        6
`define CSR_RESET           8'h00

`define SPM_WINDOW          3'h4
`define CLK_PERIOD_NS       5
`define PROG_TIME_MIN_NS    3700000
`define PROG_TIME_MAX_NS    4500000
`define TIMER_W             20

`define PC_W                13
`define Z_PC_TOP            13
`define Z_PAGE_LO           7
`define Z_WORD_TOP          6
`define Z_WORD_LO           1
`define Z_BYTE_SEL          0

`define BOOT_START_128      13'h1F80
`define BOOT_START_256      13'h1F00
`define BOOT_START_512      13'h1E00
`define BOOT_START_1024     13'h1C00
`define RWW_LIMIT           13'h1C00
`define RWW_PAGES           112
`define NONREADABLE_DURING_WRITE_REGION_PAGES          16

`endif

//--- src/selfprog_pkg.sv
// Types shared by the self-programming sequencer.
// Assumes selfprog_map.svh is on the include path.
`include "selfprog_map.svh"

package selfprog_pkg;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_PROG  = 2'b10
    } seq_state_t;

    typedef struct packed {
        seq_state_t            st;
        logic [2:0]            win_cnt;
        logic                  cmd_erase;
        logic                  cmd_write;
        logic                  cmd_lock;
        logic                  cmd_reen;
        logic                  enable;
        logic                  busy;
        logic [`TIMER_W-1:0]   timer;
        logic [6:0]            page_addr;
        logic                  erase_pulse;
        logic                  write_pulse;
        logic                  lock_pulse;
        logic                  buf_wr;
        logic [5:0]            buf_idx;
        logic [15:0]           buf_data;
        logic                  fetch_denied;
        logic                  byte_sel;
        logic [7:0]            rdata;
        logic [1:0]            fuse_s1;
        logic [1:0]            fuse_s2;
        logic [`PC_W-1:0]      boot_start;
    } seq_regs_t;

endpackage

//--- testbench/boot_core_model.sv
// Core model running the boot loader: register port, timed store strobe, pointer and data pair.
// Assumes a free-running mclk; the bench calls the tasks hierarchically, one at a time.
`timescale 1ns/1ps
`include "selfprog_map.svh"

module boot_core_model (
    input  wire logic        mclk,
    input  wire logic [7:0]  reg_rdata,
    input  wire logic        selfprog_enable_bit,
    input  wire logic        eeprom_write_in_progress_bit,
    output logic      [5:0]  reg_addr,
    output logic      [7:0]  reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic             spm_exec,
    output logic      [15:0] z_ptr,
    output logic      [7:0]  r0_data,
    output logic      [7:0]  r1_data
);
    initial begin
        reg_addr  = 6'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        spm_exec  = 1'b0;
        z_ptr     = 16'h0000;
        r0_data   = 8'h00;
        r1_data   = 8'h00;
    end

    task automatic rd_csr(input logic [5:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // A polite caller polls enable and the EEPROM flag with interrupts off; impolite calls test refusals.
    task automatic do_spm(input logic [7:0] v, input logic [15:0] z, input logic [7:0] lo,
                          input logic [7:0] hi, input int gap, input bit polite);
        while (polite && selfprog_enable_bit !== 1'b0) @(posedge mclk);
        while (polite && eeprom_write_in_progress_bit !== 1'b0) @(posedge mclk);
        @(posedge mclk);
        z_ptr     <= z;
        r0_data   <= lo;
        r1_data   <= hi;
        reg_addr  <= `CSR_ADDR;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~v;
        repeat (gap) @(posedge mclk);
        spm_exec <= 1'b1;
        @(posedge mclk);
        spm_exec <= 1'b0;
        r0_data  <= ~lo;
        r1_data  <= ~hi;
        #1;
    endtask

    // Loads the pointer as a program-memory load would, without any store.
    task automatic load_ptr(input logic [15:0] z);
        @(posedge mclk);
        z_ptr <= z;
        @(posedge mclk);
        #1;
    endtask
endmodule // boot_core_model

//--- testbench/tb.sv
// Self-checking bench for the self-programming sequencer with a short programming time.
// Assumes the package, the header and the core model are compiled first.
`timescale 1ns/1ps
`include "selfprog_map.svh"

module tb;
    import selfprog_pkg::*;
    localparam int unsigned PROG_N = 16;
    logic mclk = 1'b0, resetn = 1'b0, ee_busy = 1'b0, f_hi = 1'b1, f_lo = 1'b1;
    logic [12:0] fetch_addr = 13'h0000, boot_start;
    logic [5:0] reg_addr, word_idx;
    logic [7:0] reg_wdata, reg_rdata, r0_data, r1_data, rd;
    logic reg_wr, reg_rd, spm_exec, denied, bsel, er_p, wr_p, lk_p, buf_p, busy, en;
    logic [15:0] z_ptr, buf_data;
    logic [6:0] page;
    int fail_count = 0, num_checks = 0, cycles = 0;

    always #2.5 mclk = ~mclk;

    boot_core_model i_boot_core_model (.mclk(mclk), .reg_rdata(reg_rdata), .selfprog_enable_bit(en),
        .eeprom_write_in_progress_bit(ee_busy), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .spm_exec(spm_exec), .z_ptr(z_ptr), .r0_data(r0_data), .r1_data(r1_data));

    self_program_boot_partition #(.PROG_CYCLES(PROG_N)) i_self_program_boot_partition (.mclk(mclk),
        .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .spm_exec(spm_exec), .z_ptr(z_ptr), .r0_data(r0_data), .r1_data(r1_data),
        .eeprom_write_in_progress_bit(ee_busy), .boot_size_fuse_hi(f_hi), .boot_size_fuse_lo(f_lo),
        .fetch_addr(fetch_addr), .fetch_denied(denied), .lpm_byte_sel(bsel), .boot_start(boot_start),
        .page_erase_pulse(er_p), .page_write_pulse(wr_p), .lock_write_pulse(lk_p),
        .page_select_field(page), .buf_wr_pulse(buf_p), .word_in_page_field(word_idx),
        .buf_wr_data(buf_data), .readable_region_busy_flag(busy), .selfprog_enable_bit(en));

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A hung poll would otherwise spin forever; the ceiling is many times the expected run.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end

    // Counts cycles until enable drops, bounded.
    task automatic wait_done(output int n);
        n = 0;
        while (en !== 1'b0 && n < 200) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_boot();
        logic [12:0] exp_start [4] = '{13'h1C00, 13'h1E00, 13'h1F00, 13'h1F80};
        for (int c = 0; c < 4; c++) begin
            @(posedge mclk);
            {f_hi, f_lo} <= c[1:0];
            repeat (5) @(posedge mclk);
            #1;
            check("boot_start", {3'h0, exp_start[c]}, {3'h0, boot_start});
        end
    endtask

    task automatic t_fill();
        i_boot_core_model.do_spm(8'h01, 16'h004A, 8'hA5, 8'h3C, 0, 1);
        check("fill pulse", 16'h1, {15'h0, buf_p});
        check("word index", 16'h25, {10'h0, word_idx});
        check("fill data", 16'h3CA5, buf_data);
        check("enable after fill", 16'h0, {15'h0, en});
        i_boot_core_model.load_ptr(16'h004B);
        check("byte select", 16'h1, {15'h0, bsel});
        i_boot_core_model.do_spm(8'h01, 16'h007E, 8'hFF, 8'h00, 3, 1);
        check("late edge fill", 16'h1, {15'h0, buf_p});
        check("word index top", 16'h3F, {10'h0, word_idx});
        check("byte select low", 16'h0, {15'h0, bsel});
        i_boot_core_model.do_spm(8'h01, 16'h0002, 8'h11, 8'h22, 4, 1);
        check("expired window", 16'h0, {15'h0, buf_p});
        check("enable expired", 16'h0, {15'h0, en});
    endtask

    task automatic t_prog(input logic [7:0] cmd, input logic [6:0] pg, input logic [12:0] fa);
        int n;
        @(posedge mclk);
        fetch_addr <= fa;
        i_boot_core_model.do_spm(cmd, {2'b00, pg, 7'h00}, 8'h00, 8'h00, 0, 1);
        check("op pulse", 16'h1, {15'h0, (cmd[1] ? er_p : wr_p)});
        check("page", {9'h0, pg}, {9'h0, page});
        check("busy set", 16'h1, {15'h0, busy});
        @(posedge mclk);
        #1;
        check("fetch gate", {15'h0, fa < `RWW_LIMIT}, {15'h0, denied});
        i_boot_core_model.do_spm(8'h01, 16'h0000, 8'h5A, 8'h5A, 0, 0);
        check("fill while busy", 16'h0, {15'h0, buf_p});
        check("enable held", 16'h1, {15'h0, en});
        wait_done(n);
        check("op length", 16'h1, {15'h0, n >= PROG_N - 8 && n <= PROG_N + 2});
        repeat (2) @(posedge mclk);
        #1;
        check("gate released", 16'h0, {15'h0, denied});
        i_boot_core_model.rd_csr(`CSR_ADDR, rd);
        check("busy after op", 16'h40, {8'h0, rd & 8'h41});
        i_boot_core_model.do_spm(8'h11, 16'h0000, 8'h00, 8'h00, 0, 1);
        check("busy cleared", 16'h0, {15'h0, busy});
        check("enable cleared", 16'h0, {15'h0, en});
    endtask

    task automatic t_misc();
        int n;
        @(posedge mclk);
        ee_busy <= 1'b1;
        i_boot_core_model.do_spm(8'h01, 16'h0000, 8'h00, 8'h00, 0, 0);
        check("fill in eeprom write", 16'h0, {15'h0, buf_p});
        i_boot_core_model.rd_csr(`CSR_ADDR, rd);
        check("csr in eeprom write", 16'h0, {8'h0, rd});
        @(posedge mclk);
        ee_busy    <= 1'b0;
        fetch_addr <= 13'h0000;
        i_boot_core_model.do_spm(8'h09, 16'h0001, 8'hFF, 8'h00, 0, 1);
        check("lock pulse", 16'h1, {15'h0, lk_p});
        @(posedge mclk);
        #1;
        check("lock fetch", 16'h0, {15'h0, denied});
        wait_done(n);
        check("lock length", 16'h1, {15'h0, n >= PROG_N - 8 && n <= PROG_N + 2});
        i_boot_core_model.rd_csr(6'h10, rd);
        check("unmapped read", 16'h0, {8'h0, rd});
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        #1;
        check("reset boot_start", 16'h1C00, {3'h0, boot_start});
        check("reset enable", 16'h0, {15'h0, en});
        @(posedge mclk);
        resetn <= 1'b1;
        t_boot();
        t_fill();
        t_prog(8'h03, 7'h55, 13'h1BFF);
        t_prog(8'h05, 7'h2A, 13'h1C00);
        t_misc();
        give_verdict();
    end
endmodule // tb
